// ### rtl/ulsf_consts.svh
// Purpose: Offsets, field positions, reset values and sizes of the receive line status block.
// Assumes: Included by its bare name; holds definitions only.
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave.
//
// Behaviour
// - A character that arrives without a valid stop bit raises the framing error flag.
// - With the FIFO enabled, framing and parity flags describe the character at the head of the FIFO.
// - A character whose parity bit disagrees with the configured parity raises the parity error flag.
// - A character that completes while the FIFO has no free space raises the overrun flag.
// - On overrun the new character overwrites the earlier one in the receive shift register.
// - On overrun the shift register byte is not queued and the queued bytes stay intact.
// - The data ready flag is high while at least one character waits in the holding register or FIFO.
// - The data ready flag is low while nothing waits, and after reset.
// - The overrun, parity and framing flags reset to zero.
`ifndef ULSF_CONSTS_SVH
`define ULSF_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define ULSF_OFS_RX_DATA 4'h0
`define ULSF_OFS_LINE_STATUS 4'h4
`define ULSF_OFS_CONTROL 4'h8
`define ULSF_OFS_FIFO_LEVEL 4'hc

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define ULSF_STAT_READY_BIT 0
`define ULSF_STAT_OVERRUN_BIT 1
`define ULSF_STAT_PARITY_BIT 2
`define ULSF_STAT_FRAMING_BIT 3
`define ULSF_CTRL_FIFO_EN_BIT 0
`define ULSF_CTRL_FLUSH_BIT 1
`define ULSF_ENTRY_PARITY_BIT 8
`define ULSF_ENTRY_FRAMING_BIT 9

////////////////////////////////////////////////////////////////////////////////
// Reset values and sizes
`define ULSF_CTRL_FIFO_EN_RESET 1'b0
`define ULSF_FLAG_RESET 1'b0
`define ULSF_FIFO_DEPTH 32
`define ULSF_CHAR_W 8
`define ULSF_ENTRY_W 10
`define ULSF_BUS_W 32

`endif

// ### rtl/ulsf_line_status.sv
// Purpose: Receive FIFO and line status flags of one UART channel, on an Avalon-MM slave.
// Assumes: Receiver logic on ref_clk delivers one-cycle character strobes with error bits.
// Notes: Every access takes one wait state; read side effects happen on the first request edge.
`timescale 1ns/100ps
`include "ulsf_consts.svh"

module ulsf_line_status #(
    parameter int DEPTH = `ULSF_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Character strobe from the receive shifter
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    input wire logic rx_char_parity_err,
    input wire logic rx_char_framing_err,
    // Status toward the receiver and system
    output logic rx_fifo_full,
    output logic rx_data_ready_flag,
    output logic [7:0] rx_shift_data
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter check

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("ulsf_line_status: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic ack_ff;
    logic fifo_en_ff;
    logic overrun_ff;
    logic hide_err_ff;
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    logic [CW-1:0] nxt_count;
    logic [7:0] shift_ff;
    logic [31:0] readdata_ff;
    logic [31:0] nxt_readdata;
    logic [`ULSF_ENTRY_W-1:0] head_word;
    logic [`ULSF_ENTRY_W-1:0] push_word;
    logic [AW-1:0] rd_addr;
    logic [CW-1:0] limit;
    logic req_first;
    logic aligned;
    logic rd_status;
    logic pop;
    logic wr_ctrl;
    logic flush;
    logic full;
    logic push;
    logic ready;
    logic parity_flag;
    logic framing_flag;
    logic [7:0] status_byte;
    ulsf_pkg::ulsf_reg_t reg_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // One wait state on every access gives readdata a register to come from
    assign req_first = (avs_read || avs_write) && !ack_ff;
    assign avs_waitrequest = req_first;
    assign aligned = (avs_address[1:0] == 2'b00);
    assign reg_sel = ulsf_pkg::ulsf_reg_t'(avs_address[3:2]);

    // Read side effects on the first edge, so the snapshot and the clear agree
    assign rd_status = avs_read && !ack_ff && aligned && (reg_sel == ulsf_pkg::ulsf_reg_status);
    assign pop = avs_read && !ack_ff && aligned && (reg_sel == ulsf_pkg::ulsf_reg_data) && ready;

    // Writes take effect on the edge where waitrequest is low
    assign wr_ctrl = avs_write && ack_ff && aligned && (reg_sel == ulsf_pkg::ulsf_reg_control)
                     && avs_byteenable[0];

    // Flush on request, or when the FIFO mode changes, so no entry spans both modes
    assign flush = wr_ctrl && (avs_writedata[`ULSF_CTRL_FLUSH_BIT]
                   || (avs_writedata[`ULSF_CTRL_FIFO_EN_BIT] != fifo_en_ff));

    // Access phase
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req_first;
        end
    end

    // Control register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fifo_en_ff <= `ULSF_CTRL_FIFO_EN_RESET;
        end else if (wr_ctrl) begin
            fifo_en_ff <= avs_writedata[`ULSF_CTRL_FIFO_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive queue

    // Without FIFO mode the queue is a single holding register
    assign limit = fifo_en_ff ? CW'(DEPTH) : CW'(1);
    assign full = (count_ff >= limit);
    assign ready = (count_ff != '0);
    assign push = rx_char_valid && !full && !flush;
    assign push_word = {rx_char_framing_err, rx_char_parity_err, rx_char_data};
    assign rd_addr = flush ? '0 : (pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff);

    // Occupancy; a character arriving during a flush is dropped
    always_comb begin
        nxt_count = count_ff;
        if (flush) begin
            nxt_count = '0;
        end else if (push && !pop) begin
            nxt_count = CW'(count_ff + 1'b1);
        end else if (pop && !push) begin
            nxt_count = CW'(count_ff - 1'b1);
        end
    end

    // Pointers and count
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_ff <= '0;
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            count_ff <= nxt_count;
            rd_ptr_ff <= rd_addr;
            if (flush) begin
                wr_ptr_ff <= '0;
            end else if (push) begin
                wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
            end
        end
    end

    // Error bits travel with their character
    ulsf_rx_mem #(
        .WIDTH(`ULSF_ENTRY_W),
        .AW(AW)
    ) u_mem (
        .ref_clk(ref_clk),
        .wr_en(push),
        .wr_addr(wr_ptr_ff),
        .wr_data(push_word),
        .rd_addr(rd_addr),
        .rd_data(head_word)
    );

    // Shift register copy; always takes the newest character, even on overrun
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            shift_ff <= '0;
        end else if (rx_char_valid) begin
            shift_ff <= rx_char_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Line status flags

    // Overrun sticky; a new overrun wins over the clearing read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            overrun_ff <= `ULSF_FLAG_RESET;
        end else if (rx_char_valid && full && !flush) begin
            overrun_ff <= 1'b1;
        end else if (rd_status) begin
            overrun_ff <= 1'b0;
        end
    end

    // Head error already reported; a new head character shows its errors afresh
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hide_err_ff <= 1'b0;
        end else if (pop || flush) begin
            hide_err_ff <= 1'b0;
        end else if (rd_status && ready) begin
            hide_err_ff <= 1'b1;
        end
    end

    // Errors describe the head entry, not the newest arrival
    assign parity_flag = ready && head_word[`ULSF_ENTRY_PARITY_BIT] && !hide_err_ff;
    assign framing_flag = ready && head_word[`ULSF_ENTRY_FRAMING_BIT] && !hide_err_ff;

    // Status byte; unused bits read zero
    always_comb begin
        status_byte = 8'h00;
        status_byte[`ULSF_STAT_READY_BIT] = ready;
        status_byte[`ULSF_STAT_OVERRUN_BIT] = overrun_ff;
        status_byte[`ULSF_STAT_PARITY_BIT] = parity_flag;
        status_byte[`ULSF_STAT_FRAMING_BIT] = framing_flag;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data

    // Unmapped or misaligned reads return zero
    always_comb begin
        nxt_readdata = 32'h0000_0000;
        if (aligned) begin
            case (reg_sel)
                ulsf_pkg::ulsf_reg_data: begin
                    nxt_readdata = ready ? {24'h00_0000, head_word[7:0]} : 32'h0000_0000;
                end
                ulsf_pkg::ulsf_reg_status: begin
                    nxt_readdata = {24'h00_0000, status_byte};
                end
                ulsf_pkg::ulsf_reg_control: begin
                    nxt_readdata = {31'h0000_0000, fifo_en_ff};
                end
                ulsf_pkg::ulsf_reg_level: begin
                    nxt_readdata = 32'(count_ff);
                end
                default: begin
                    nxt_readdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Captured on the first edge, stands through the accepting edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            readdata_ff <= 32'h0000_0000;
        end else if (avs_read && !ack_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign avs_readdata = readdata_ff;
    assign rx_fifo_full = full;
    assign rx_data_ready_flag = ready;
    assign rx_shift_data = shift_ff;

endmodule : ulsf_line_status

// ### rtl/ulsf_pkg.sv
// Purpose: Types shared by the receive line status block.
// Assumes: Constants live in ulsf_consts.svh.
// Notes: Register select is the word index, address bits 3:2.
package ulsf_pkg;

    // Word index of a register
    typedef enum logic [1:0] {
        ulsf_reg_data = 2'b00,
        ulsf_reg_status = 2'b01,
        ulsf_reg_control = 2'b10,
        ulsf_reg_level = 2'b11
    } ulsf_reg_t;

    // One received character
    typedef logic [7:0] ulsf_char_t;

endpackage : ulsf_pkg

// ### rtl/ulsf_rx_mem.sv
// Purpose: Receive FIFO storage with a registered read port.
// Assumes: Single clock; one write and one read address per cycle.
// Notes: A write to the address being read is bypassed so the head is never stale.
`timescale 1ns/100ps
`include "ulsf_consts.svh"

module ulsf_rx_mem #(
    parameter int WIDTH = `ULSF_ENTRY_W,
    parameter int AW = 5
) (
    // Clock
    input wire logic ref_clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [0:(1 << AW)-1];
    logic [WIDTH-1:0] rd_data_ff;

    // Storage has no reset; only the counter says what is valid
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read with write-through
    always_ff @(posedge ref_clk) begin
        if (wr_en && (wr_addr == rd_addr)) begin
            rd_data_ff <= wr_data;
        end else begin
            rd_data_ff <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_ff;

endmodule : ulsf_rx_mem

// ### testbench/ulsf_line_status_properties.sv
// Purpose: Bus and flag properties of the line status block.
// Assumes: One clock, async active-low reset.
// Notes: Status reads take effect on their first wait edge.
`timescale 1ns/100ps
module ulsf_line_status_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Receive side
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    input wire logic rx_fifo_full,
    input wire logic rx_data_ready_flag,
    input wire logic [7:0] rx_shift_data
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic stat_rd;
    logic wr_done;
    logic ovr_ff;
    logic ctl_en_ff;
    logic flush_now;
    ////////////////////////////////////////
    // Status read edge; a finished write may flush
    assign stat_rd = avs_read && avs_waitrequest && avs_address == 4'h4;
    assign wr_done = avs_write && !avs_waitrequest;
    // Flush bit or a mode change drops a character arriving in the same cycle
    assign flush_now = wr_done && avs_address == 4'h8 && avs_byteenable[0]
                       && (avs_writedata[1] || avs_writedata[0] != ctl_en_ff);
    // Own copy of the FIFO mode bit, from accepted control writes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctl_en_ff <= 1'b0;
        end else if (wr_done && avs_address == 4'h8 && avs_byteenable[0]) begin
            ctl_en_ff <= avs_writedata[0];
        end
    end
    // Expected overrun, a new overrun beats the clearing read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ovr_ff <= 1'b0;
        end else begin
            ovr_ff <= (rx_char_valid && rx_fifo_full && !flush_now) || (ovr_ff && !stat_rd);
        end
    end
    ////////////////////////////////////////
    a_push_ready: assert property (rx_char_valid && !rx_fifo_full && !wr_done |=> rx_data_ready_flag)
        else $error("ready missing after push");
    a_ready_fall: assert property ($fell(rx_data_ready_flag) |-> $past(avs_read || avs_write))
        else $error("ready fell without access");
    a_full_ready: assert property (rx_fifo_full |-> rx_data_ready_flag)
        else $error("full but not ready");
    a_ovr_keep: assert property (rx_char_valid && rx_fifo_full && !avs_read && !avs_write |=> rx_fifo_full)
        else $error("overrun disturbed queue");
    a_shift_take: assert property (rx_char_valid |=> rx_shift_data == $past(rx_char_data))
        else $error("shift data not replaced");
    a_ovr_report: assert property (stat_rd |=> avs_readdata[1] == $past(ovr_ff))
        else $error("overrun flag wrong");
    a_ready_report: assert property (stat_rd |=> avs_readdata[0] == $past(rx_data_ready_flag))
        else $error("ready bit wrong");
    a_reset_clean: assert property ($rose(nrst) |-> !rx_data_ready_flag && !rx_fifo_full)
        else $error("flags set after reset");
    a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
    // Main scenarios
    cover property (stat_rd && ovr_ff);
    cover property (rx_char_valid && rx_fifo_full);
    cover property ($fell(rx_data_ready_flag));
endmodule : ulsf_line_status_properties

// ### testbench/ulsf_line_status_test.sv
// Purpose: Self-checking bench of the line status block.
// Assumes: Default depth, one wait state per access.
// Notes: A queue model predicts every data and status read.
`timescale 1ns/100ps
module ulsf_line_status_test;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, rx_fifo_full, rx_data_ready_flag;
    logic rx_char_valid, rx_char_parity_err, rx_char_framing_err;
    logic [7:0] rx_char_data, rx_shift_data;
    logic [9:0] mq[$];
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int depth = 1;
    bit movr = 0;
    bit mhide = 0;
    always #12.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////
    ulsf_line_status dut (.ref_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .rx_char_valid, .rx_char_data,
        .rx_char_parity_err, .rx_char_framing_err, .rx_fifo_full, .rx_data_ready_flag, .rx_shift_data);
    ulsf_rx_partner partner (.ref_clk, .rx_char_valid, .rx_char_data, .rx_char_parity_err,
        .rx_char_framing_err);
    ////////////////////////////////////////
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Held until waitrequest is seen low, then released
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task push(input logic [7:0] d, input logic pe, input logic fe);
        partner.send(d, pe, fe);
        if (mq.size() < depth) mq.push_back({fe, pe, d});
        else movr = 1;
        chk("shift", {24'h0, d}, {24'h0, rx_shift_data});
    endtask : push
    // Errors of the head are hidden once read
    task stat;
        logic [3:0] e;
        bus(1'b0, 4'h4, 32'h0);
        e = {2'b00, movr, mq.size() != 0};
        if (mq.size() != 0 && !mhide) e[3:2] = mq[0][9:8];
        chk("status", {28'h0, e}, q);
        chk("ready", {31'h0, mq.size() != 0}, {31'h0, rx_data_ready_flag});
        movr = 0;
        mhide = mq.size() != 0;
    endtask : stat
    task pop;
        logic [31:0] e;
        e = mq.size() != 0 ? {24'h0, mq[0][7:0]} : 32'h0;
        bus(1'b0, 4'h0, 32'h0);
        chk("data", e, q);
        if (mq.size() != 0) mq.delete(0);
        mhide = 0;
    endtask : pop
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////
    // Hang guard, far above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(42205));
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        stat();
        push(8'ha5, 1'b1, 1'b0);
        stat();
        stat();
        push(8'h3c, 1'b0, 1'b1);
        stat();
        pop();
        stat();
        bus(1'b1, 4'h8, 32'h1);
        mq.delete();
        depth = 32;
        for (int i = 0; i < 33; i++) push(8'($urandom), 1'($urandom), 1'($urandom));
        chk("full", 32'h1, {31'h0, rx_fifo_full});
        bus(1'b0, 4'hc, 32'h0);
        chk("level", 32'h20, q);
        for (int i = 0; i < 32; i++) begin
            stat();
            pop();
        end
        stat();
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
        // Flush bit empties the queue and keeps FIFO mode
        push(8'h5a, 1'b0, 1'b1);
        push(8'h96, 1'b1, 1'b0);
        bus(1'b1, 4'h8, 32'h3);
        mq.delete();
        stat();
        bus(1'b0, 4'h8, 32'h0);
        chk("control", 32'h1, q);
        // Holding register mode, overrun with head errors, then a reset in mid-run
        bus(1'b1, 4'h8, 32'h0);
        depth = 1;
        push(8'h11, 1'b1, 1'b1);
        push(8'h22, 1'b0, 1'b0);
        stat();
        push(8'h33, 1'b0, 1'b0);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        mq.delete();
        movr = 0;
        mhide = 0;
        stat();
        bus(1'b0, 4'hc, 32'h0);
        chk("level", 32'h0, q);
        bus(1'b0, 4'h8, 32'h0);
        chk("control", 32'h0, q);
        report_and_stop();
    end
endmodule : ulsf_line_status_test
bind ulsf_line_status ulsf_line_status_properties u_props (.ref_clk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_char_valid,
    .rx_char_data, .rx_fifo_full,
    .rx_data_ready_flag, .rx_shift_data);

// ### testbench/ulsf_rx_partner.sv
// Purpose: Remote transmitter as seen after the receive shifter.
// Assumes: Called just after a rising edge.
// Notes: Error bits are sent only when a test asks for them.
`timescale 1ns/100ps
module ulsf_rx_partner (
    // Clock
    input wire logic ref_clk,
    // Character strobe
    output logic rx_char_valid,
    output logic [7:0] rx_char_data,
    output logic rx_char_parity_err,
    output logic rx_char_framing_err
);
    ////////////////////////////////////////
    initial begin
        rx_char_valid = 1'b0;
        rx_char_data = 8'h00;
        rx_char_parity_err = 1'b0;
        rx_char_framing_err = 1'b0;
    end
    // Lines invert after the pulse so stale data never looks valid
    task send(input logic [7:0] d, input logic pe, input logic fe);
        rx_char_valid <= 1'b1;
        rx_char_data <= d;
        rx_char_parity_err <= pe;
        rx_char_framing_err <= fe;
        @(posedge ref_clk);
        rx_char_valid <= 1'b0;
        rx_char_data <= ~d;
        rx_char_parity_err <= ~pe;
        rx_char_framing_err <= ~fe;
        @(posedge ref_clk);
    endtask : send
endmodule : ulsf_rx_partner
